// File: shared/pmd_pkg.sv
// Constants, field positions and carrier types for the parallel move decoder.
// Assumes a 32-bit instruction word; the data register file sits outside.
`default_nettype none
package pmd_pkg;
  localparam int unsigned PMD_WORD_W = 32;
  localparam int unsigned PMD_ALU_W = 14;
  // X memory plus register copy form: 010d WdYY YXXX ADDR_MODE_FIELD ...
  localparam logic [2:0] PMD_XFORM_KEY = 3'h2;
  localparam int unsigned PMD_XFORM_HI = 31;
  localparam int unsigned PMD_XFORM_LO = 29;
  localparam int unsigned PMD_DD_HI_BIT = 28;
  localparam int unsigned PMD_DD_LO_BIT = 26;
  localparam int unsigned PMD_W_BIT = 27;
  localparam int unsigned PMD_YYY_LO = 23;
  localparam int unsigned PMD_XXX_LO = 20;
  // Y memory form: 0011 W1DD DDDD ADDR_MODE_FIELD ...
  localparam logic [3:0] PMD_YFORM_KEY = 4'h3;
  localparam int unsigned PMD_SPACE_BIT = 26;
  localparam int unsigned PMD_DREG_LO = 20;
  // Long displacement form: 0000 11DD DDDD 1W1R ...
  localparam logic [5:0] PMD_LDISP_KEY = 6'h03;
  localparam int unsigned PMD_LD_SPACE_BIT = 19;
  localparam int unsigned PMD_LD_W_BIT = 18;
  localparam int unsigned PMD_LD_ONE_BIT = 17;
  // Effective address field MMMRRR
  localparam int unsigned PMD_MODE_LO = 17;
  localparam int unsigned PMD_PTR_LO = 14;
  localparam logic [2:0] PMD_MODE_ABS = 3'h6;
  localparam logic [2:0] PMD_MODE_RSVD = 3'h7;
  localparam logic [2:0] PMD_PTR_IMM = 3'h4;
  // Opcode bit that marks a floating-point arithmetic opcode
  localparam int unsigned PMD_FP_BIT = 13;

  typedef enum logic [1:0] {
    PMD_PORT_S = 2'b00,
    PMD_PORT_L = 2'b01,
    PMD_PORT_M = 2'b10,
    PMD_PORT_H = 2'b11
  } pmd_portion_e;

  typedef struct packed {
    logic [2:0] idx;
    pmd_portion_e portion;
  } pmd_rd_s;

  typedef struct packed {
    logic en;
    logic [2:0] idx;
    pmd_portion_e portion;
    logic [31:0] data;
  } pmd_wr_s;

  typedef struct packed {
    logic valid;
    logic space_y;
    logic write;
    logic [2:0] ptr;
    logic [2:0] mode;
    logic long_disp;
    logic has_ext;
    logic [31:0] ext;
    logic [31:0] wdata;
  } pmd_mem_s;

  typedef struct packed {
    logic legal;
    logic form_y;
    logic long_disp;
    logic load;
    logic immediate;
    logic need_ext;
    logic has_copy;
    logic [2:0] mode;
    logic [2:0] ptr;
    logic [2:0] mem_idx;
    pmd_portion_e mem_portion;
    logic [2:0] cpy_dst;
    logic [2:0] cpy_src;
    pmd_portion_e cpy_portion;
  } pmd_dec_s;
endpackage : pmd_pkg
`default_nettype wire

// File: logic/pmd_decoder.sv
// Parallel move decoder: X memory move with register copy, Y memory move.
// Assumes fetch stream, memories and register file answer synchronously to mclk.
// Function
// - X form does one X memory word move plus one register copy.
// - Move may read a register the arithmetic also uses; both see it.
// - Transfer direction comes from the W bit of the instruction word.
// - Direction bit 0 stores register to memory, 1 loads register.
// - Three-bit field selects register 0-7, long or single by opcode kind.
// - Copy destination field; source from the opposite half via two bits.
// - Extension word fetched when mode needs absolute address or immediate.
// - Address field names one of eight pointers; memory modes only.
// - Cost is address cycles plus access cycles; words per mode.
// - Y form moves exactly one word with Y memory either way.
// - Y form takes modes 0-6 (reserved mode 7 refused), absolute and immediate too; immediate only for loads.
// - Long displacement from extra word added to chosen pointer.
`timescale 1ns/10ps
`default_nettype none
module pmd_decoder
  import pmd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ins_valid,
  input wire logic [31:0] ins_word,
  output logic ins_ready,
  output logic [13:0] alu_op,
  output logic alu_valid,
  output logic illegal,
  output pmd_rd_s rd_mem,
  output pmd_rd_s rd_cpy,
  input wire logic [31:0] rd_mem_data,
  input wire logic [31:0] rd_cpy_data,
  output pmd_mem_s mem_req,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output pmd_wr_s wr_mem,
  output pmd_wr_s wr_cpy,
  output logic busy
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic pmd_portion_e pmd_kind(input logic [31:0] w);
    pmd_kind = w[PMD_FP_BIT] ? PMD_PORT_S : PMD_PORT_L;
  endfunction : pmd_kind

  function automatic pmd_dec_s pmd_dec(input logic [31:0] w);
    pmd_dec_s r;
    logic xf;
    logic yf;
    logic ld;
    r = '0;
    xf = (w[PMD_XFORM_HI:PMD_XFORM_LO] == PMD_XFORM_KEY);
    yf = (w[31:28] == PMD_YFORM_KEY) && w[PMD_SPACE_BIT];
    ld = (w[31:26] == PMD_LDISP_KEY) && w[PMD_LD_SPACE_BIT] && w[PMD_LD_ONE_BIT];
    r.form_y = yf | ld;
    r.long_disp = ld;
    r.load = ld ? w[PMD_LD_W_BIT] : w[PMD_W_BIT];
    r.mode = w[PMD_MODE_LO +: 3];
    r.ptr = w[PMD_PTR_LO +: 3];
    r.immediate = !ld && (r.mode == PMD_MODE_ABS) && (r.ptr == PMD_PTR_IMM);
    r.need_ext = ld || (r.mode == PMD_MODE_ABS);
    r.has_copy = xf;
    if (xf) begin
      r.mem_idx = w[PMD_XXX_LO +: 3];
      r.mem_portion = pmd_kind(w);
    end else begin
      r.mem_idx = w[PMD_DREG_LO +: 3];
      r.mem_portion = pmd_portion_e'(w[PMD_DREG_LO + 3 +: 2]);
    end
    r.cpy_dst = w[PMD_YYY_LO +: 3];
    // Source always lies in the half opposite the destination
    r.cpy_src = {~r.cpy_dst[2], w[PMD_DD_HI_BIT], w[PMD_DD_LO_BIT]};
    r.cpy_portion = pmd_kind(w);
    r.legal = (xf || yf || ld)
      && (ld || r.mode != PMD_MODE_RSVD)
      && !(r.immediate && !r.load)
      && !(r.form_y && w[PMD_DREG_LO + 5]);
    return r;
  endfunction : pmd_dec

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    PMD_ST_IDLE = 2'b00,
    PMD_ST_EXT = 2'b01,
    PMD_ST_MEM = 2'b10,
    PMD_ST_DONE = 2'b11
  } pmd_state_e;

  pmd_state_e st_q, st_d;
  logic [31:0] ins_q, ins_d;
  logic [31:0] ext_q, ext_d;
  logic [31:0] mval_q, mval_d;
  logic [31:0] cval_q, cval_d;
  logic [13:0] alu_q, alu_d;
  logic alu_v_q, alu_v_d;
  logic ill_q, ill_d;
  pmd_dec_s dn;
  pmd_dec_s dq;
  logic take;

  assign dn = pmd_dec(ins_word);
  assign dq = pmd_dec(ins_q);
  assign ins_ready = (st_q == PMD_ST_IDLE) || (st_q == PMD_ST_EXT);
  assign take = ins_valid && (st_q == PMD_ST_IDLE);
  assign busy = (st_q != PMD_ST_IDLE);

  // Both reads happen in the decode cycle, so the arithmetic sees the same values
  always_comb begin
    rd_mem.idx = dn.mem_idx;
    rd_mem.portion = dn.mem_portion;
    rd_cpy.idx = dn.cpy_src;
    rd_cpy.portion = dn.cpy_portion;
  end

  always_comb begin
    st_d = st_q;
    ins_d = ins_q;
    ext_d = ext_q;
    mval_d = mval_q;
    cval_d = cval_q;
    alu_d = alu_q;
    alu_v_d = 1'b0;
    ill_d = 1'b0;
    case (st_q)
      PMD_ST_IDLE: begin
        if (take) begin
          alu_d = ins_word[PMD_ALU_W-1:0];
          alu_v_d = 1'b1;
          if (!dn.legal) begin
            ill_d = 1'b1;
          end else begin
            ins_d = ins_word;
            mval_d = rd_mem_data;
            cval_d = rd_cpy_data;
            st_d = dn.need_ext ? PMD_ST_EXT : PMD_ST_MEM;
          end
        end
      end
      PMD_ST_EXT: begin
        if (ins_valid) begin
          ext_d = ins_word;
          if (dq.immediate) begin
            mval_d = ins_word;
            st_d = PMD_ST_DONE;
          end else begin
            st_d = PMD_ST_MEM;
          end
        end
      end
      PMD_ST_MEM: begin
        if (mem_ack) begin
          if (dq.load) begin
            mval_d = mem_rdata;
          end
          st_d = PMD_ST_DONE;
        end
      end
      PMD_ST_DONE: begin
        st_d = PMD_ST_IDLE;
      end
      default: begin
        st_d = PMD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= PMD_ST_IDLE;
      ins_q <= 32'h0000_0000;
      ext_q <= 32'h0000_0000;
      mval_q <= 32'h0000_0000;
      cval_q <= 32'h0000_0000;
      alu_q <= 14'h0000;
      alu_v_q <= 1'b0;
      ill_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ins_q <= ins_d;
      ext_q <= ext_d;
      mval_q <= mval_d;
      cval_q <= cval_d;
      alu_q <= alu_d;
      alu_v_q <= alu_v_d;
      ill_q <= ill_d;
    end
  end

  assign alu_op = alu_q;
  assign alu_valid = alu_v_q;
  assign illegal = ill_q;

  ////////////////////////////////////////////////////////////////////////////
  // Request holds steady from flops until the memory acknowledges
  always_comb begin
    mem_req.valid = (st_q == PMD_ST_MEM);
    mem_req.space_y = dq.form_y;
    mem_req.write = !dq.load;
    mem_req.ptr = dq.ptr;
    mem_req.mode = dq.mode;
    mem_req.long_disp = dq.long_disp;
    mem_req.has_ext = dq.need_ext;
    mem_req.ext = ext_q;
    mem_req.wdata = mval_q;
  end

  // Both destinations written in one cycle; copy uses the decode-time source value
  always_comb begin
    wr_mem.en = (st_q == PMD_ST_DONE) && dq.load;
    wr_mem.idx = dq.mem_idx;
    wr_mem.portion = dq.mem_portion;
    wr_mem.data = mval_q;
    wr_cpy.en = (st_q == PMD_ST_DONE) && dq.has_copy;
    wr_cpy.idx = dq.cpy_dst;
    wr_cpy.portion = dq.cpy_portion;
    wr_cpy.data = cval_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_alu_decode: assert property (@(posedge mclk) disable iff (!rst_n)
    take |=> alu_valid && alu_op == $past(ins_word[13:0]))
    else $error("arithmetic part not issued after decode");

  a_copy_half: assert property (@(posedge mclk) disable iff (!rst_n)
    take && dn.has_copy |-> rd_cpy.idx[2] != ins_word[PMD_YYY_LO + 2]
      && rd_cpy.idx[1:0] == {ins_word[PMD_DD_HI_BIT], ins_word[PMD_DD_LO_BIT]})
    else $error("copy source not in opposite half");

  a_copy_value: assert property (@(posedge mclk) disable iff (!rst_n)
    take && dn.legal && dn.has_copy |=> cval_q == $past(rd_cpy_data))
    else $error("copy value not captured at decode");

  // Copy value must survive any memory wait states untouched
  a_copy_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    busy |=> $stable(cval_q))
    else $error("copy value changed");

  a_store_dir: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == PMD_ST_MEM) && !dq.load |=> !wr_mem.en)
    else $error("store wrote a register");

  a_load_data: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == PMD_ST_MEM) && mem_ack && dq.load |=> wr_mem.en && wr_mem.data == $past(mem_rdata))
    else $error("load data not written");

  a_ext_needed: assert property (@(posedge mclk) disable iff (!rst_n)
    take && dn.legal |=> (st_q == PMD_ST_EXT) == $past(dn.need_ext))
    else $error("extension fetch mismatch");

  a_mem_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    mem_req.valid && !mem_ack |=> mem_req.valid && $stable(mem_req))
    else $error("memory request dropped before ack");

  a_x_portion: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_cpy.en |-> wr_mem.portion == wr_cpy.portion
      && wr_cpy.portion == (alu_op[PMD_FP_BIT] ? PMD_PORT_S : PMD_PORT_L))
    else $error("move portions differ");

  a_y_space: assert property (@(posedge mclk) disable iff (!rst_n)
    mem_req.valid |-> mem_req.space_y == !dq.has_copy)
    else $error("wrong memory space");

  a_imm_nomem: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == PMD_ST_EXT) && ins_valid && dq.immediate |=> !mem_req.valid ##1 !mem_req.valid)
    else $error("immediate issued memory access");

  a_illegal_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    take && !dn.legal |=> illegal && (st_q == PMD_ST_IDLE))
    else $error("bad mode not refused");

  a_mode_refused: assert property (@(posedge mclk) disable iff (!rst_n)
    take && (ins_word[PMD_MODE_LO +: 3] == PMD_MODE_RSVD) && !dn.long_disp |=> illegal)
    else $error("reserved mode accepted");

  a_ext_take: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == PMD_ST_EXT) && ins_valid |=> ext_q == $past(ins_word))
    else $error("extension word not captured");

  a_y_one_word: assert property (@(posedge mclk) disable iff (!rst_n)
    mem_req.valid && mem_ack |=> !mem_req.valid)
    else $error("second memory word requested");

  // Synchronous reset: the cycle after it busy, alu_valid, illegal and mem_req.valid are low
  a_reset_idle: assert property (@(posedge mclk)
    !rst_n |=> !busy && !alu_valid && !illegal && !mem_req.valid)
    else $error("not idle after reset");

  // Main scenarios: load, store, long displacement, immediate
  c_x_load: cover property (@(posedge mclk) disable iff (!rst_n)
    wr_mem.en && wr_cpy.en);
  c_y_store: cover property (@(posedge mclk) disable iff (!rst_n)
    mem_req.valid && mem_req.space_y && mem_req.write && mem_ack);
  c_long_disp: cover property (@(posedge mclk) disable iff (!rst_n)
    mem_req.valid && mem_req.long_disp && mem_ack);
  c_immediate: cover property (@(posedge mclk) disable iff (!rst_n)
    (st_q == PMD_ST_EXT) && ins_valid && dq.immediate);
  c_x_store: cover property (@(posedge mclk) disable iff (!rst_n)
    wr_cpy.en && !wr_mem.en);

endmodule : pmd_decoder
`default_nettype wire

// File: test/pmd_mem_model.sv
// Behavioural X/Y data memory that answers the decoder's memory requests.
// Assumes mem_req comes from flops clocked on the rising edge of mclk.
`timescale 1ns/10ps
`default_nettype none
module pmd_mem_model
  import pmd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] dly,
  input wire pmd_mem_s mem_req,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [3:0] cnt;
  logic [31:0] word;
  assign word = 32'h5A00_0000 | {29'h0, mem_req.ptr};
  // Data is only valid with ack; otherwise inverted so stale capture shows
  assign mem_rdata = mem_ack ? word : ~word;
  always @(negedge mclk) begin
    if (!rst_n || !mem_req.valid || mem_ack) begin
      cnt <= 4'h0;
      mem_ack <= 1'b0;
    end else if (cnt == dly) begin
      mem_ack <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : pmd_mem_model
`default_nettype wire

// File: test/parallel_move_decoder_test.sv
// Self-checking bench for the parallel move decoder.
// Assumes pmd_pkg is compiled first and the memory model answers requests.
`timescale 1ns/10ps
`default_nettype none
module parallel_move_decoder_test;
  import pmd_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ins_valid = 1'b0;
  logic [31:0] ins_word = 32'h0;
  logic [3:0] dly = 4'h0;
  logic ins_ready, alu_valid, illegal, mem_ack, busy, av, il, rb;
  logic [13:0] alu_op, aop;
  logic [31:0] rd_mem_data, rd_cpy_data, mem_rdata;
  pmd_rd_s rd_mem, rd_cpy;
  pmd_mem_s mem_req, rq;
  pmd_wr_s wr_mem, wr_cpy, wm, wc;
  int rn;
  int n_mismatch = 0;
  int n_checks = 0;
  always #10 mclk = ~mclk;
  // Register file stand-in: each value encodes its own select
  assign rd_mem_data = 32'h1100_0000 | {27'h0, rd_mem};
  assign rd_cpy_data = 32'h2200_0000 | {27'h0, rd_cpy};
  pmd_decoder DUT (.mclk(mclk), .rst_n(rst_n), .ins_valid(ins_valid), .ins_word(ins_word),
    .ins_ready(ins_ready), .alu_op(alu_op), .alu_valid(alu_valid), .illegal(illegal),
    .rd_mem(rd_mem), .rd_cpy(rd_cpy), .rd_mem_data(rd_mem_data), .rd_cpy_data(rd_cpy_data),
    .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .wr_mem(wr_mem),
    .wr_cpy(wr_cpy), .busy(busy));
  pmd_mem_model u_mem (.mclk(mclk), .rst_n(rst_n), .dly(dly), .mem_req(mem_req),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rf(input logic [31:0] b, input logic [2:0] i,
    input logic [1:0] p);
    return b | {27'h0, i, p};
  endfunction : rf
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  // Offer one instruction (plus optional extension) and log what comes back
  task automatic run(input logic [31:0] w, input logic ext_on, input logic [31:0] ext);
    rn = 0;
    rb = 1'b0;
    wm = '0;
    wc = '0;
    rq = '0;
    @(negedge mclk);
    ins_valid = 1'b1;
    ins_word = w;
    @(negedge mclk);
    av = alu_valid;
    aop = alu_op;
    il = illegal;
    if (ext_on) begin
      ins_word = ext;
      @(negedge mclk);
    end
    ins_valid = 1'b0;
    ins_word = ~w;
    for (int k = 0; k < 20 && busy !== 1'b0; k++) begin
      if (mem_req.valid === 1'b1 && rn == 0) begin
        rq = mem_req;
        rn++;
      end
      if (mem_req.valid === 1'b1 && ins_ready !== 1'b0) rb = 1'b1;
      if (wr_mem.en === 1'b1) wm = wr_mem;
      if (wr_cpy.en === 1'b1) wc = wr_cpy;
      @(negedge mclk);
    end
    chk("idle", 1'b0, busy);
    chk("ready", 2'b01, {rb, ins_ready});
  endtask : run
  ////////////////////////////////////////////////////////////////////////////
  task automatic x_load;
    dly = 4'h0;
    run({3'b010, 1'b1, 1'b1, 1'b0, 3'h1, 3'h5, 3'h0, 3'h3, 14'h0123}, 1'b0, 32'h0);
    chk("alu_op", {1'b1, 14'h0123}, {av, aop});
    chk("x dir", {1'b1, 1'b0, 1'b0, 3'h3}, {rq.valid, rq.space_y, rq.write, rq.ptr});
    chk("x load", {1'b1, 3'h5, PMD_PORT_L, 32'h5A00_0003}, wm);
    chk("copy", {1'b1, 3'h1, PMD_PORT_L, rf(32'h2200_0000, 3'h6, PMD_PORT_L)}, wc);
    $display("x_load done");
  endtask : x_load
  task automatic x_store;
    dly = 4'h3;
    run({3'b010, 1'b0, 1'b0, 1'b1, 3'h5, 3'h2, 3'h1, 3'h7, 14'h2001}, 1'b0, 32'h0);
    chk("x store", {2'b01, 3'h1, rf(32'h1100_0000, 3'h2, PMD_PORT_S)},
      {rq.space_y, rq.write, rq.mode, rq.wdata});
    chk("no load", 1'b0, wm.en);
    chk("one move", 1, rn);
    chk("copy fp", {1'b1, 3'h5, PMD_PORT_S, rf(32'h2200_0000, 3'h1, PMD_PORT_S)}, wc);
    $display("x_store done");
  endtask : x_store
  task automatic y_moves;
    run({4'b0011, 1'b1, 1'b1, 6'h0B, 3'h6, 3'h4, 14'h0040}, 1'b1, 32'hCAFE_F00D);
    chk("imm no mem", 0, rn);
    chk("imm load", {1'b1, 3'h3, PMD_PORT_L, 32'hCAFE_F00D}, wm);
    chk("y no copy", 1'b0, wc.en);
    dly = 4'h2;
    run({4'b0011, 1'b0, 1'b1, 6'h06, 3'h6, 3'h0, 14'h0}, 1'b1, 32'h0000_0123);
    chk("abs store", {4'hE, 32'h0000_0123, rf(32'h1100_0000, 3'h6, PMD_PORT_S)},
      {rq.space_y, rq.write, rq.has_ext, rq.long_disp, rq.ext, rq.wdata});
    chk("y one word", 1, rn);
    run({6'h03, 6'h0C, 1'b1, 1'b0, 1'b1, 3'h5, 14'h0}, 1'b1, 32'hFFFF_FFF0);
    chk("long disp", {4'hF, 3'h5, 32'hFFFF_FFF0, rf(32'h1100_0000, 3'h4, PMD_PORT_L)},
      {rq.space_y, rq.write, rq.has_ext, rq.long_disp, rq.ptr, rq.ext, rq.wdata});
    $display("y_moves done");
  endtask : y_moves
  task automatic refused;
    logic [31:0] bad [3];
    bad = '{{3'b010, 3'b010, 3'h1, 3'h5, 3'h7, 3'h2, 14'h0},
      {4'b0011, 1'b0, 1'b1, 6'h0B, 3'h6, 3'h4, 14'h0},
      {6'h03, 6'h0B, 1'b0, 1'b1, 1'b1, 3'h1, 14'h0}};
    foreach (bad[i]) begin
      run(bad[i], 1'b0, 32'h0);
      chk("refused", {3'b110, 1'b0}, {av, il, rn[0], wm.en});
    end
    $display("refused done");
  endtask : refused
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    chk("reset", 7'h01, {busy, alu_valid, illegal, mem_req.valid, wr_mem.en, wr_cpy.en,
      ins_ready});
    x_load;
    x_store;
    y_moves;
    refused;
    give_verdict;
  end
  // Tests need well under a thousand cycles
  initial begin
    #100000;
    n_mismatch++;
    give_verdict;
  end
endmodule : parallel_move_decoder_test
`default_nettype wire
